// >>> hdl/motion_config_register_bank.sv
// Transient, pulse, control, interrupt and offset register bank
//
// What this block does
// RULE1: Burst read advances address by one
// RULE2: After last offset register, next address wraps
// RULE3: Registers keep contents entering idle state
// RULE4: Status registers clear entering measuring state
// RULE5: Thresholds and debounce writable in both states
// RULE6: Threshold or debounce write resets debounce counter
// RULE7: Other writes refused while measuring, except run/reset
// RULE8: Auto-increment only on burst reads
// RULE9: Stop condition clears stored address
// RULE10: All registers reset to zero
// RULE11: Status registers are read-only
// RULE12: Pin map steers sources to pins
// RULE13: Host idles device before rewriting configuration
// RULE14: Sequence independent of fifo and fast-read
`timescale 1ns/1ps
`default_nettype none
module motion_config_register_bank
  import motion_bank_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic addr_load,
  input wire logic [7:0] addr_value,
  input wire logic write_strobe,
  input wire logic [7:0] write_data,
  input wire logic read_strobe,
  input wire logic burst_read,
  input wire logic stop_detected,
  input wire logic transient_status_load,
  input wire logic [7:0] transient_status_value,
  input wire logic pulse_status_load,
  input wire logic [7:0] pulse_status_value,
  input wire logic [7:0] interrupt_sources,
  output logic [7:0] read_data,
  output logic read_valid,
  output logic write_refused,
  output logic measuring,
  output logic soft_reset,
  output logic transient_debounce_clear,
  output logic pulse_debounce_clear,
  output logic [8*REG_COUNT-1:0] config_image,
  output logic interrupt_pin_one,
  output logic interrupt_pin_two,
  output logic [7:0] current_address
);

  // ***************************************************************
  // Bank indices
  // ***************************************************************
  // Slot k of the bank holds the register at FIRST_ADDR plus k
  localparam logic [4:0] IDX_TRANSIENT_CONFIG = 5'(TRANSIENT_CONFIG_ADDR - FIRST_ADDR);
  localparam logic [4:0] IDX_TRANSIENT_STATUS = 5'(TRANSIENT_STATUS_ADDR - FIRST_ADDR);
  localparam logic [4:0] IDX_TRANSIENT_THRESHOLD = 5'(TRANSIENT_THRESHOLD_ADDR - FIRST_ADDR);
  localparam logic [4:0] IDX_TRANSIENT_DEBOUNCE = 5'(TRANSIENT_DEBOUNCE_ADDR - FIRST_ADDR);
  localparam logic [4:0] IDX_PULSE_CONFIG = 5'(PULSE_CONFIG_ADDR - FIRST_ADDR);
  localparam logic [4:0] IDX_PULSE_STATUS = 5'(PULSE_STATUS_ADDR - FIRST_ADDR);
  localparam logic [4:0] IDX_PULSE_THRESHOLD_X = 5'(PULSE_THRESHOLD_X_ADDR - FIRST_ADDR);
  localparam logic [4:0] IDX_PULSE_THRESHOLD_Y = 5'(PULSE_THRESHOLD_Y_ADDR - FIRST_ADDR);
  localparam logic [4:0] IDX_PULSE_THRESHOLD_Z = 5'(PULSE_THRESHOLD_Z_ADDR - FIRST_ADDR);
  localparam logic [4:0] IDX_PULSE_TIME_LIMIT = 5'(PULSE_TIME_LIMIT_ADDR - FIRST_ADDR);
  localparam logic [4:0] IDX_PULSE_LATENCY = 5'(PULSE_LATENCY_ADDR - FIRST_ADDR);
  localparam logic [4:0] IDX_PULSE_SECOND_WINDOW = 5'(PULSE_SECOND_WINDOW_ADDR - FIRST_ADDR);
  localparam logic [4:0] IDX_SLEEP_COUNTER = 5'(SLEEP_COUNTER_ADDR - FIRST_ADDR);
  localparam logic [4:0] IDX_CONTROL_ONE = 5'(CONTROL_ONE_ADDR - FIRST_ADDR);
  localparam logic [4:0] IDX_CONTROL_TWO = 5'(CONTROL_TWO_ADDR - FIRST_ADDR);
  localparam logic [4:0] IDX_CONTROL_THREE = 5'(CONTROL_THREE_ADDR - FIRST_ADDR);
  localparam logic [4:0] IDX_INTERRUPT_ENABLE = 5'(INTERRUPT_ENABLE_ADDR - FIRST_ADDR);
  localparam logic [4:0] IDX_INTERRUPT_PIN_MAP = 5'(INTERRUPT_PIN_MAP_ADDR - FIRST_ADDR);
  localparam logic [4:0] IDX_OFFSET_X_AXIS = 5'(OFFSET_X_AXIS_ADDR - FIRST_ADDR);
  localparam logic [4:0] IDX_OFFSET_Y_AXIS = 5'(OFFSET_Y_AXIS_ADDR - FIRST_ADDR);
  localparam logic [4:0] IDX_OFFSET_Z_AXIS = 5'(OFFSET_Z_AXIS_ADDR - FIRST_ADDR);

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic [REG_COUNT-1:0][7:0] bank;
    mode_t mode;
    logic [7:0] read_data;
    logic read_valid;
    logic write_refused;
    logic soft_reset;
    logic transient_clear;
    logic pulse_clear;
    logic pin_one;
    logic pin_two;
  } bank_state_t;

  localparam bank_state_t STATE_RESET = '{
    bank: {REG_COUNT{RESET_VALUE}},
    mode: MODE_IDLE,
    read_data: RESET_VALUE,
    read_valid: 1'b0,
    write_refused: 1'b0,
    soft_reset: 1'b0,
    transient_clear: 1'b0,
    pulse_clear: 1'b0,
    pin_one: 1'b0,
    pin_two: 1'b0
  };

  bank_state_t state;
  bank_state_t next_state;

  pointer_port_if pointer_port ();

  logic [7:0] addr;
  logic in_range;
  logic [4:0] idx;
  logic is_measuring;
  logic [7:0] routed_sources;
  logic write_hit;
  logic write_stray;
  logic [7:0] pin_one_sources;
  logic [7:0] pin_two_sources;

  // ***************************************************************
  // Address pointer
  // ***************************************************************
  assign pointer_port.load = addr_load;
  assign pointer_port.load_value = addr_value;
  // Single reads and writes leave the pointer where it is
  assign pointer_port.advance = read_strobe && burst_read; // see RULE8
  assign pointer_port.clear = stop_detected; // see RULE9

  auto_increment_pointer u_auto_increment_pointer (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .port(pointer_port.owner)
  );

  assign addr = pointer_port.address;
  assign in_range = (addr >= FIRST_ADDR) && (addr <= LAST_ADDR);
  assign idx = 5'(addr - FIRST_ADDR);
  assign is_measuring = (state.mode == MODE_MEASURING);

  // ***************************************************************
  // Access decode
  // ***************************************************************
  // Writes outside the bank are refused; other register logic owns them
  assign write_hit = write_strobe && in_range;
  assign write_stray = write_strobe && !in_range;

  // ***************************************************************
  // Interrupt routing
  // ***************************************************************
  assign routed_sources = interrupt_sources & state.bank[IDX_INTERRUPT_ENABLE];
  // Each enabled source lands on exactly one pin
  assign pin_one_sources = routed_sources & state.bank[IDX_INTERRUPT_PIN_MAP];
  assign pin_two_sources = routed_sources & ~state.bank[IDX_INTERRUPT_PIN_MAP];

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    next_state = state;
    next_state.read_valid = 1'b0;
    next_state.write_refused = 1'b0;
    next_state.soft_reset = 1'b0;
    next_state.transient_clear = 1'b0;
    next_state.pulse_clear = 1'b0;

    // ********
    // Read path
    // ********
    // Addresses outside the bank belong to other logic and read as zero
    if (read_strobe) begin
      next_state.read_valid = 1'b1;
      case (addr)
        TRANSIENT_CONFIG_ADDR: next_state.read_data = state.bank[IDX_TRANSIENT_CONFIG];
        TRANSIENT_STATUS_ADDR: next_state.read_data = state.bank[IDX_TRANSIENT_STATUS];
        TRANSIENT_THRESHOLD_ADDR: next_state.read_data = state.bank[IDX_TRANSIENT_THRESHOLD];
        TRANSIENT_DEBOUNCE_ADDR: next_state.read_data = state.bank[IDX_TRANSIENT_DEBOUNCE];

        PULSE_CONFIG_ADDR: next_state.read_data = state.bank[IDX_PULSE_CONFIG];
        PULSE_STATUS_ADDR: next_state.read_data = state.bank[IDX_PULSE_STATUS];
        PULSE_THRESHOLD_X_ADDR: next_state.read_data = state.bank[IDX_PULSE_THRESHOLD_X];
        PULSE_THRESHOLD_Y_ADDR: next_state.read_data = state.bank[IDX_PULSE_THRESHOLD_Y];
        PULSE_THRESHOLD_Z_ADDR: next_state.read_data = state.bank[IDX_PULSE_THRESHOLD_Z];
        PULSE_TIME_LIMIT_ADDR: next_state.read_data = state.bank[IDX_PULSE_TIME_LIMIT];
        PULSE_LATENCY_ADDR: next_state.read_data = state.bank[IDX_PULSE_LATENCY];
        PULSE_SECOND_WINDOW_ADDR: next_state.read_data = state.bank[IDX_PULSE_SECOND_WINDOW];

        SLEEP_COUNTER_ADDR: next_state.read_data = state.bank[IDX_SLEEP_COUNTER];
        CONTROL_ONE_ADDR: next_state.read_data = state.bank[IDX_CONTROL_ONE];
        CONTROL_TWO_ADDR: next_state.read_data = state.bank[IDX_CONTROL_TWO];
        CONTROL_THREE_ADDR: next_state.read_data = state.bank[IDX_CONTROL_THREE];

        INTERRUPT_ENABLE_ADDR: next_state.read_data = state.bank[IDX_INTERRUPT_ENABLE];
        INTERRUPT_PIN_MAP_ADDR: next_state.read_data = state.bank[IDX_INTERRUPT_PIN_MAP];

        OFFSET_X_AXIS_ADDR: next_state.read_data = state.bank[IDX_OFFSET_X_AXIS];
        OFFSET_Y_AXIS_ADDR: next_state.read_data = state.bank[IDX_OFFSET_Y_AXIS];
        OFFSET_Z_AXIS_ADDR: next_state.read_data = state.bank[IDX_OFFSET_Z_AXIS];
        default: next_state.read_data = UNMAPPED_READ_VALUE;
      endcase
    end

    // ********
    // Write path
    // ********
    if (write_hit) begin
      case (addr)
        TRANSIENT_STATUS_ADDR,
        PULSE_STATUS_ADDR: begin
          next_state.write_refused = 1'b1; // see RULE11
        end
        TRANSIENT_THRESHOLD_ADDR,
        TRANSIENT_DEBOUNCE_ADDR: begin
          next_state.bank[idx] = write_data; // see RULE5
          next_state.transient_clear = 1'b1; // see RULE6
        end
        PULSE_THRESHOLD_X_ADDR,
        PULSE_THRESHOLD_Y_ADDR,
        PULSE_THRESHOLD_Z_ADDR: begin
          next_state.bank[idx] = write_data; // see RULE5
          next_state.pulse_clear = 1'b1; // see RULE6
        end
        CONTROL_ONE_ADDR: begin
          if (is_measuring) begin
            // Only the run/stop bit moves while measuring
            next_state.bank[idx][ACTIVE_BIT] = write_data[ACTIVE_BIT]; // see RULE7
          end else begin
            next_state.bank[idx] = write_data;
          end
        end
        CONTROL_TWO_ADDR: begin
          if (!is_measuring) begin
            next_state.bank[idx] = write_data;
          end
          // Soft reset is honoured in either state
          next_state.soft_reset = write_data[SOFT_RESET_BIT]; // see RULE7
        end
        TRANSIENT_CONFIG_ADDR,
        PULSE_CONFIG_ADDR,
        PULSE_TIME_LIMIT_ADDR,
        PULSE_LATENCY_ADDR,
        PULSE_SECOND_WINDOW_ADDR,
        SLEEP_COUNTER_ADDR,
        CONTROL_THREE_ADDR,
        INTERRUPT_ENABLE_ADDR,
        INTERRUPT_PIN_MAP_ADDR,
        OFFSET_X_AXIS_ADDR,
        OFFSET_Y_AXIS_ADDR,
        OFFSET_Z_AXIS_ADDR: begin
          // Settings must not shift under a running detector
          if (is_measuring) begin
            next_state.write_refused = 1'b1; // see RULE7
          end else begin
            next_state.bank[idx] = write_data;
          end
        end
        default: begin
          // Every bank address is listed above; anything else is refused
          next_state.write_refused = 1'b1;
        end
      endcase
    end else if (write_stray) begin
      next_state.write_refused = 1'b1;
    end

    // ********
    // Operating mode
    // ********
    // Mode follows the run/stop bit; leaving measuring touches no register
    case (state.mode)
      MODE_IDLE: begin
        if (next_state.bank[IDX_CONTROL_ONE][ACTIVE_BIT]) begin
          next_state.mode = MODE_MEASURING;
          next_state.bank[IDX_TRANSIENT_STATUS] = RESET_VALUE; // see RULE4
          next_state.bank[IDX_PULSE_STATUS] = RESET_VALUE; // see RULE4
        end
      end
      MODE_MEASURING: begin
        if (!next_state.bank[IDX_CONTROL_ONE][ACTIVE_BIT]) begin
          next_state.mode = MODE_IDLE; // see RULE3
        end
      end
      default: begin
        next_state.mode = MODE_IDLE;
      end
    endcase

    // ********
    // Detector loads
    // ********
    // Detector updates win over the clear on entry to measuring
    if (transient_status_load) begin
      next_state.bank[IDX_TRANSIENT_STATUS] = transient_status_value;
    end
    if (pulse_status_load) begin
      next_state.bank[IDX_PULSE_STATUS] = pulse_status_value;
    end

    // ********
    // Interrupt pins
    // ********
    // Pin map: a set bit sends the source to pin one, a clear bit to pin two
    next_state.pin_one = |pin_one_sources; // see RULE12
    next_state.pin_two = |pin_two_sources; // see RULE12

    // ********
    // Soft reset
    // ********
    // Soft reset returns the whole bank to its reset image
    if (state.soft_reset) begin
      next_state.bank = STATE_RESET.bank; // see RULE10
      next_state.mode = MODE_IDLE;
    end
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  always_ff @(posedge clock) begin
    // Reset overrides the enable so a frozen bank can still be cleared
    if (rst) begin
      state <= STATE_RESET; // see RULE10
    end else if (ce) begin
      state <= next_state;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign read_data = state.read_data;
  assign read_valid = state.read_valid;
  assign write_refused = state.write_refused;
  assign measuring = is_measuring;

  // Soft reset and debounce clear pulses below last a single enabled cycle
  assign soft_reset = state.soft_reset;
  assign transient_debounce_clear = state.transient_clear;
  assign pulse_debounce_clear = state.pulse_clear;
  assign config_image = state.bank;
  assign interrupt_pin_one = state.pin_one;
  assign interrupt_pin_two = state.pin_two;
  assign current_address = addr;

endmodule
`default_nettype wire

// >>> shared/motion_bank_pkg.sv
// Constants, addresses and types shared by the motion configuration register bank
package motion_bank_pkg;

  // ***************************************************************
  // Register addresses
  // ***************************************************************
  localparam logic [7:0] TRANSIENT_CONFIG_ADDR = 8'h1d;
  localparam logic [7:0] TRANSIENT_STATUS_ADDR = 8'h1e;
  localparam logic [7:0] TRANSIENT_THRESHOLD_ADDR = 8'h1f;
  localparam logic [7:0] TRANSIENT_DEBOUNCE_ADDR = 8'h20;
  localparam logic [7:0] PULSE_CONFIG_ADDR = 8'h21;
  localparam logic [7:0] PULSE_STATUS_ADDR = 8'h22;
  localparam logic [7:0] PULSE_THRESHOLD_X_ADDR = 8'h23;
  localparam logic [7:0] PULSE_THRESHOLD_Y_ADDR = 8'h24;
  localparam logic [7:0] PULSE_THRESHOLD_Z_ADDR = 8'h25;
  localparam logic [7:0] PULSE_TIME_LIMIT_ADDR = 8'h26;
  localparam logic [7:0] PULSE_LATENCY_ADDR = 8'h27;
  localparam logic [7:0] PULSE_SECOND_WINDOW_ADDR = 8'h28;
  localparam logic [7:0] SLEEP_COUNTER_ADDR = 8'h29;
  localparam logic [7:0] CONTROL_ONE_ADDR = 8'h2a;
  localparam logic [7:0] CONTROL_TWO_ADDR = 8'h2b;
  localparam logic [7:0] CONTROL_THREE_ADDR = 8'h2c;
  localparam logic [7:0] INTERRUPT_ENABLE_ADDR = 8'h2d;
  localparam logic [7:0] INTERRUPT_PIN_MAP_ADDR = 8'h2e;
  localparam logic [7:0] OFFSET_X_AXIS_ADDR = 8'h2f;
  localparam logic [7:0] OFFSET_Y_AXIS_ADDR = 8'h30;
  localparam logic [7:0] OFFSET_Z_AXIS_ADDR = 8'h31;

  // ***************************************************************
  // Bank layout and values
  // ***************************************************************
  localparam int REG_COUNT = 21;
  localparam logic [7:0] FIRST_ADDR = TRANSIENT_CONFIG_ADDR;
  localparam logic [7:0] LAST_ADDR = OFFSET_Z_AXIS_ADDR;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;
  localparam logic [7:0] WRAP_TARGET_ADDR = 8'h0d;
  localparam logic [7:0] CLEARED_ADDR = 8'h00;
  localparam logic [7:0] ADDR_STEP = 8'h01;
  localparam int ACTIVE_BIT = 0;
  localparam int SOFT_RESET_BIT = 6;

  // ***************************************************************
  // Operating mode
  // ***************************************************************
  typedef enum logic [1:0] {
    MODE_IDLE = 2'b01,
    MODE_MEASURING = 2'b10
  } mode_t;

endpackage

// >>> shared/pointer_port_if.sv
// Link between the register bank and its auto-increment address pointer
`timescale 1ns/1ps
`default_nettype none
interface pointer_port_if;
  logic load;
  logic [7:0] load_value;
  logic advance;
  logic clear;
  logic [7:0] address;

  modport owner (
    input load,
    input load_value,
    input advance,
    input clear,
    output address
  );

  modport user (
    output load,
    output load_value,
    output advance,
    output clear,
    input address
  );
endinterface
`default_nettype wire

// >>> hdl/auto_increment_pointer.sv
// Register address pointer with burst auto-increment and wrap
`timescale 1ns/1ps
`default_nettype none
module auto_increment_pointer
  import motion_bank_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  pointer_port_if.owner port
);

  typedef struct packed {
    logic [7:0] address;
  } pointer_state_t;

  pointer_state_t state;
  pointer_state_t next_state;

  // ***************************************************************
  // Next address
  // ***************************************************************
  always_comb begin
    next_state = state;
    // Stop has priority so a stray advance cannot survive the end of a transfer
    if (port.clear) begin
      next_state.address = CLEARED_ADDR; // see RULE9
    end else if (port.load) begin
      next_state.address = port.load_value;
    end else if (port.advance) begin
      // Sequence is fixed; no fifo or fast-read setting reaches here (see RULE14)
      if (state.address == LAST_ADDR) begin
        next_state.address = WRAP_TARGET_ADDR; // see RULE2
      end else begin
        next_state.address = state.address + ADDR_STEP; // see RULE1
      end
    end
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= '{address: CLEARED_ADDR};
    end else if (ce) begin
      state <= next_state;
    end
  end

  assign port.address = state.address;

endmodule
`default_nettype wire

// >>> verif/motion_bank_chk.sv
// Port checks for the motion configuration register bank
`timescale 1ns/1ps
`default_nettype none
module motion_bank_chk
  import motion_bank_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic addr_load,
  input wire logic [7:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  input wire logic burst_read,
  input wire logic stop_detected,
  input wire logic write_refused,
  input wire logic measuring,
  input wire logic soft_reset,
  input wire logic transient_debounce_clear,
  input wire logic pulse_debounce_clear,
  input wire logic [7:0] current_address
);
  // ****
  // Properties
  // ****
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  logic mv;
  logic wr;
  logic [7:0] ca;
  // Soft reset never reaches the pointer, but it is left out as well
  assign mv = ce && !stop_detected && !addr_load && !soft_reset;
  assign wr = ce && write_strobe;
  assign ca = current_address;
  property p_step;
    mv && read_strobe && burst_read && ca inside {[8'h1d:8'h30]} |=> ca == $past(ca) + 8'h01;
  endproperty
  a_step: assert property (p_step) else $error("burst step wrong");
  property p_wrap;
    mv && read_strobe && burst_read && ca == 8'h31 |=> ca == 8'h0d;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap wrong");
  property p_hold;
    mv && !(read_strobe && burst_read) |=> $stable(ca);
  endproperty
  a_hold: assert property (p_hold) else $error("pointer moved");
  property p_stop;
    ce && stop_detected |=> ca == 8'h00;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not cleared");
  property p_ro;
    wr && ca inside {8'h1e, 8'h22} |=> write_refused;
  endproperty
  a_ro: assert property (p_ro) else $error("status write taken");
  property p_open;
    wr && ca inside {[8'h1f:8'h20], [8'h23:8'h25]} |=> !write_refused;
  endproperty
  a_open: assert property (p_open) else $error("threshold refused");
  property p_tclr;
    wr && ca inside {[8'h1f:8'h20]} |=> transient_debounce_clear && !pulse_debounce_clear;
  endproperty
  a_tclr: assert property (p_tclr) else $error("transient clear");
  property p_pclr;
    wr && ca inside {[8'h23:8'h25]} |=> pulse_debounce_clear && !transient_debounce_clear;
  endproperty
  a_pclr: assert property (p_pclr) else $error("pulse clear");
  property p_lock;
    wr && measuring && ca inside {8'h1d, 8'h21, [8'h26:8'h29], [8'h2c:8'h31]} |=> write_refused;
  endproperty
  a_lock: assert property (p_lock) else $error("locked write taken");
  property p_soft;
    wr && ca == 8'h2b && write_data[6] |=> soft_reset ##1 !measuring;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset lost");
  c_lock: cover property (wr && measuring);
  c_wrap: cover property (read_strobe && burst_read && ca == 8'h31);
  c_soft: cover property (soft_reset);
endmodule
bind motion_config_register_bank motion_bank_chk u_motion_bank_chk (.*);
`default_nettype wire

// >>> verif/host_byte_model.sv
// Host byte access model for the register bank request pins
`timescale 1ns/1ps
`default_nettype none
module host_byte_model (
  input wire logic clock,
  output logic addr_load,
  output logic [7:0] addr_value,
  output logic write_strobe,
  output logic [7:0] write_data,
  output logic read_strobe,
  output logic burst_read,
  output logic stop_detected
);
  // ****
  // Byte transfers; released lines carry the inverse so stale data never matches
  // ****
  initial begin
    {addr_load, write_strobe, read_strobe, burst_read, stop_detected} = 5'h00;
    {addr_value, write_data} = 16'h0000;
  end
  task automatic point(input logic [7:0] a);
    @(posedge clock);
    addr_load <= 1'b1;
    addr_value <= a;
    @(posedge clock);
    addr_load <= 1'b0;
    addr_value <= ~a;
  endtask
  task automatic put(input logic [7:0] d);
    @(posedge clock);
    write_strobe <= 1'b1;
    write_data <= d;
    @(posedge clock);
    write_strobe <= 1'b0;
    write_data <= ~d;
  endtask
  task automatic get(input logic b);
    @(posedge clock);
    read_strobe <= 1'b1;
    burst_read <= b;
    @(posedge clock);
    read_strobe <= 1'b0;
    burst_read <= ~b;
  endtask
  task automatic halt;
    @(posedge clock);
    stop_detected <= 1'b1;
    @(posedge clock);
    stop_detected <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> verif/motion_config_register_bank_tb_top.sv
// Self-checking bench for the motion configuration register bank
`timescale 1ns/1ps
`default_nettype none
module motion_config_register_bank_tb_top;
  import motion_bank_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic addr_load, write_strobe, read_strobe, burst_read, stop_detected;
  logic read_valid, write_refused, measuring, soft_reset;
  logic transient_debounce_clear, pulse_debounce_clear, interrupt_pin_one, interrupt_pin_two;
  logic [7:0] addr_value, write_data, read_data, current_address;
  logic transient_status_load = 1'b0;
  logic pulse_status_load = 1'b0;
  logic [7:0] transient_status_value = 8'h00;
  logic [7:0] pulse_status_value = 8'h00;
  logic [7:0] interrupt_sources = 8'h00;
  logic [8*REG_COUNT-1:0] config_image;
  logic [7:0] sh [0:255];
  logic [7:0] q [$];
  logic meas = 1'b0;
  int errors = 0;
  int check_count = 0;
  motion_config_register_bank u_motion_config_register_bank (.*);
  host_byte_model u_host_byte_model (.*);
  initial begin
    forever #50 clock = ~clock;
  end
  // ****
  // Shared tasks
  // ****
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    u_host_byte_model.point(a);
    u_host_byte_model.put(d);
    if (a == CONTROL_ONE_ADDR) begin
      if (!meas && d[0]) begin
        sh[8'h1e] = 8'h00;
        sh[8'h22] = 8'h00;
      end
      sh[a] = meas ? {sh[a][7:1], d[0]} : d;
      meas = d[0];
    end else if (a inside {[8'h1f:8'h20], [8'h23:8'h25]}) begin
      sh[a] = d;
    end else if (!meas && a inside {8'h1d, 8'h21, [8'h26:8'h29], [8'h2b:8'h31]}) begin
      sh[a] = d;
    end
  endtask
  task automatic rburst(input logic [7:0] a, input int n, input logic b);
    u_host_byte_model.point(a);
    repeat (n) begin
      q.push_back(sh[a]);
      u_host_byte_model.get(b);
      if (b) a = (a == LAST_ADDR) ? WRAP_TARGET_ADDR : a + ADDR_STEP;
    end
    #1 chk("current_address", a, current_address);
  endtask
  task automatic close_out;
    for (int i = 0; i < 100 && q.size() != 0; i++) @(posedge clock);
    if (q.size() != 0) errors++;
    $display("checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    if (read_valid === 1'b1) begin
      if (q.size() == 0) chk("read_valid", 8'h00, 8'h01);
      else chk("read_data", q.pop_front(), read_data);
    end
  end
  initial begin
    repeat (30000) @(posedge clock);
    errors++;
    close_out();
  end
  // ****
  // Main sequence
  // ****
  initial begin
    void'($urandom(31544));
    foreach (sh[i]) sh[i] = 8'h00;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1 chk("config_image", 8'h00, {7'h00, config_image !== '0});
    rburst(FIRST_ADDR, 22, 1'b1);
    // Idle pass; run bit and soft reset bit kept low
    for (int a = 8'h1d; a <= 8'h31; a++) wreg(8'(a), 8'($urandom) & 8'hbe);
    rburst(FIRST_ADDR, 22, 1'b1);
    u_host_byte_model.halt();
    #1 chk("current_address", CLEARED_ADDR, current_address);
    rburst(8'h24, 2, 1'b0);
    $display("test access done");
    @(posedge clock);
    {transient_status_load, pulse_status_load} <= 2'b11;
    transient_status_value <= 8'h5a;
    pulse_status_value <= 8'ha5;
    @(posedge clock);
    {transient_status_load, pulse_status_load} <= 2'b00;
    sh[8'h1e] = 8'h5a;
    sh[8'h22] = 8'ha5;
    rburst(TRANSIENT_STATUS_ADDR, 5, 1'b1);
    wreg(CONTROL_ONE_ADDR, 8'h03);
    #1 chk("measuring", 8'h01, {7'h00, measuring});
    rburst(FIRST_ADDR, 21, 1'b1);
    // Run bit stays set so the pass stays in measuring
    for (int a = 8'h1d; a <= 8'h31; a++) wreg(8'(a), 8'($urandom) & 8'hbe | 8'(a == 8'h2a));
    wreg(CONTROL_ONE_ADDR, 8'h00);
    rburst(FIRST_ADDR, 21, 1'b1);
    $display("test modes done");
    wreg(INTERRUPT_ENABLE_ADDR, 8'($urandom));
    wreg(INTERRUPT_PIN_MAP_ADDR, 8'($urandom));
    repeat (8) begin
      @(posedge clock);
      interrupt_sources <= 8'($urandom);
      @(posedge clock);
      #1 chk("pin_one", 8'(|(interrupt_sources & sh[8'h2d] & sh[8'h2e])), 8'(interrupt_pin_one));
      chk("pin_two", 8'(|(interrupt_sources & sh[8'h2d] & ~sh[8'h2e])), 8'(interrupt_pin_two));
    end
    $display("test pins done");
    wreg(CONTROL_ONE_ADDR, 8'h01);
    wreg(CONTROL_TWO_ADDR, 8'h40);
    @(posedge clock);
    #1 chk("config_image", 8'h00, {7'h00, config_image !== '0});
    chk("measuring", 8'h00, {7'h00, measuring});
    $display("test soft reset done");
    // Enable low must freeze the pointer and the bank
    u_host_byte_model.point(PULSE_THRESHOLD_X_ADDR);
    ce <= 1'b0;
    u_host_byte_model.put(8'h3c);
    u_host_byte_model.halt();
    ce <= 1'b1;
    #1 chk("current_address", PULSE_THRESHOLD_X_ADDR, current_address);
    chk("config_image", 8'h00, {7'h00, config_image !== '0});
    $display("test enable done");
    close_out();
  end
endmodule
`default_nettype wire
